// ---- rtl/fpdc_pkg.sv ----
// shared constants and types for the front-panel drive control block
package fpdc_pkg;
  // clock and timing
  localparam int CLK_KHZ       = 50000;
  localparam int DEBOUNCE_MS   = 10;
  localparam int DEBOUNCE_CYC  = DEBOUNCE_MS * CLK_KHZ;
  localparam int ENC_FILT_US   = 200;
  localparam int ENC_FILT_CYC  = ENC_FILT_US * CLK_KHZ / 1000;
  localparam int BLINK_MS      = 250;
  localparam int BLINK_CYC     = BLINK_MS * CLK_KHZ;
  localparam logic [3:0] IDENT_HALF_BLINKS = 4'h8;

  // encoder scaling
  localparam int ENC_DET_REV   = 24;
  localparam int FULL_TURNS    = 12;
  localparam int COARSE_RATIO  = 10;
  localparam int SP_W          = 15;
  localparam int BRIGHT_W      = 4;
  localparam logic [BRIGHT_W-1:0] BRIGHT_RST = 4'h8;
  localparam logic [BRIGHT_W-1:0] BRIGHT_MAX = 4'hF;

  // per-limit step unit and printed volts
  localparam logic [2:0] UNIT_75  = 3'h3;
  localparam logic [2:0] UNIT_100 = 3'h4;
  localparam logic [2:0] UNIT_150 = 3'h6;
  localparam logic [7:0] VOLTS_75  = 8'h4B;
  localparam logic [7:0] VOLTS_100 = 8'h64;
  localparam logic [7:0] VOLTS_150 = 8'h96;

  typedef enum logic [1:0] {RES_COARSE, RES_FINE, RES_PARKED} fpdc_res_e;
  typedef enum logic [1:0] {LIM_75, LIM_100, LIM_150} fpdc_lim_e;

  // apb register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_VSET   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_PSET   = 8'h0C;
  localparam int CTRL_IDENT_BIT = 0;
  localparam int CTRL_ZERO_BIT  = 1;
  localparam int ST_CLOSED_BIT  = 0;
  localparam int ST_ZEROED_BIT  = 1;
  localparam int ST_ZEROING_BIT = 2;
  localparam int ST_MICRONS_BIT = 3;
  localparam int ST_LEDIT_BIT   = 4;
  localparam int ST_LEGACY_BIT  = 5;
  localparam int ST_IDENT_BIT   = 6;
  localparam int ST_RES_LSB     = 8;
  localparam int ST_LIM_LSB     = 10;
  localparam int ST_BRIGHT_LSB  = 12;
endpackage

// ---- rtl/fpdc_debounce.sv ----
// two-flop synchroniser plus stability filter for a vector of slow inputs
`timescale 1ns/10ps
module fpdc_debounce #(
  parameter int WIDTH = 1,
  parameter int CNT   = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] clean
);
  localparam int CW = $clog2(CNT + 1);
  localparam logic [CW-1:0] CNT_TOP = CW'(CNT);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] clean_q;
  logic [CW-1:0]    cnt_q [WIDTH];

  if (CNT < 1) begin : g_bad_cnt
    $error("fpdc_debounce: CNT must be at least 1");
  end

  // first flop feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
    end
  end

  // accept a new level only after CNT steady cycles
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        cnt_q[i]   <= '0;
        clean_q[i] <= 1'b0;
      end else if (sync_q[i] == clean_q[i]) begin
        cnt_q[i] <= '0;
      end else if (cnt_q[i] == CNT_TOP - 1'b1) begin
        cnt_q[i]   <= '0;
        clean_q[i] <= sync_q[i];
      end else begin
        cnt_q[i] <= cnt_q[i] + 1'b1;
      end
    end
  end

  assign clean = clean_q;
endmodule // fpdc_debounce

// ---- rtl/fpdc_front_panel.sv ----
// front-panel mode, setpoint, limit, zeroing and display control with apb access
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
module fpdc_front_panel
  import fpdc_pkg::*;
#(
  parameter int DEBOUNCE_CNT = fpdc_pkg::DEBOUNCE_CYC,
  parameter int ENC_FILT_CNT = fpdc_pkg::ENC_FILT_CYC,
  parameter int BLINK_CNT    = fpdc_pkg::BLINK_CYC,
  parameter int ENC_DET      = fpdc_pkg::ENC_DET_REV
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          btn_res,
  input  wire logic                          btn_zero,
  input  wire logic                          btn_lim,
  input  wire logic                          btn_loop,
  input  wire logic                          btn_unit,
  input  wire logic                          enc_a,
  input  wire logic                          enc_b,
  input  wire logic                          legacy_stage,
  input  wire logic                          zero_done,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [fpdc_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  output logic      [fpdc_pkg::SP_W-1:0]     volt_setpoint,
  output logic      [fpdc_pkg::SP_W-1:0]     pos_setpoint,
  output logic      [1:0]                    drive_limit,
  output logic      [1:0]                    res_mode,
  output logic                               zero_start,
  output logic                               led_closed,
  output logic                               led_zeroed,
  output logic                               led_microns,
  output logic                               disp_on,
  output logic                               disp_limit_mode,
  output logic      [7:0]                    disp_limit_volts,
  output logic      [fpdc_pkg::BRIGHT_W-1:0] disp_brightness
);
  import fpdc_pkg::*;

  localparam int BCW = $clog2(BLINK_CNT + 1);
  localparam logic [BCW-1:0] BLINK_TOP = BCW'(BLINK_CNT - 1);
  localparam int FULL_DET = ENC_DET * FULL_TURNS * COARSE_RATIO;

  if (BLINK_CNT < 2 || ENC_DET < 1 || FULL_DET * 6 >= (1 << SP_W)) begin : g_bad_par
    $error("fpdc_front_panel: parameter out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // step unit: ceiling, fine and coarse steps all scale with it
  function automatic logic [2:0] unit_f(input fpdc_lim_e l);
    case (l)
      LIM_75:  unit_f = UNIT_75;
      LIM_100: unit_f = UNIT_100;
      LIM_150: unit_f = UNIT_150;
      default: unit_f = UNIT_75;
    endcase
  endfunction

  function automatic logic [SP_W-1:0] ceil_f(input fpdc_lim_e l);
    ceil_f = SP_W'(FULL_DET * int'(unit_f(l)));
  endfunction

  function automatic logic [7:0] volts_f(input fpdc_lim_e l);
    case (l)
      LIM_75:  volts_f = VOLTS_75;
      LIM_100: volts_f = VOLTS_100;
      LIM_150: volts_f = VOLTS_150;
      default: volts_f = VOLTS_75;
    endcase
  endfunction

  // saturating step; no hidden overrun is kept at either end
  function automatic logic [SP_W-1:0] sat_f(input logic [SP_W-1:0] sp,
                                           input logic [SP_W-1:0] stp,
                                           input logic            up,
                                           input logic [SP_W-1:0] top);
    logic [SP_W:0] sum;
    sum = {1'b0, sp} + {1'b0, stp};
    if (up) sat_f = (sum > {1'b0, top}) ? top : sum[SP_W-1:0];
    else sat_f = (sp < stp) ? '0 : sp - stp;
  endfunction

  function automatic logic [SP_W-1:0] min_f(input logic [SP_W-1:0] a,
                                           input logic [SP_W-1:0] b);
    min_f = (a > b) ? b : a;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input conditioning

  logic [5:0] btn_db;
  logic [1:0] enc_db;
  logic [5:0] btn_prev_q;
  logic       enc_a_prev_q;

  // buttons and legacy detect share the long filter
  fpdc_debounce #(.WIDTH(6), .CNT(DEBOUNCE_CNT)) u_btn_db (
    .clk   (clk),
    .rst_n (rst_n),
    .raw   ({legacy_stage, btn_unit, btn_loop, btn_lim, btn_zero, btn_res}),
    .clean (btn_db)
  );

  // encoder needs a much shorter filter to keep up with fast turning
  fpdc_debounce #(.WIDTH(2), .CNT(ENC_FILT_CNT)) u_enc_db (
    .clk   (clk),
    .rst_n (rst_n),
    .raw   ({enc_b, enc_a}),
    .clean (enc_db)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      btn_prev_q   <= '0;
      enc_a_prev_q <= 1'b0;
    end else begin
      btn_prev_q   <= btn_db;
      enc_a_prev_q <= enc_db[0];
    end
  end

  // one step per detent on the rising edge of a; b gives the direction
  wire       res_held  = btn_db[0];
  wire [5:0] btn_press = btn_db & ~btn_prev_q;
  wire [5:0] btn_rel   = ~btn_db & btn_prev_q;
  wire       legacy    = btn_db[5];
  wire       enc_step  = enc_db[0] & ~enc_a_prev_q;
  wire       enc_cw    = enc_step & ~enc_db[1];
  wire       enc_ccw   = enc_step & enc_db[1];

  ////////////////////////////////////////////////////////////////////////////
  // state

  fpdc_res_e            res_q;
  fpdc_lim_e            lim_q;
  fpdc_lim_e            cand_q;
  logic                 res_used_q;
  logic                 lim_edit_q;
  logic                 closed_q;
  logic                 microns_q;
  logic                 zeroing_q;
  logic                 zeroed_q;
  logic                 zero_start_q;
  logic [SP_W-1:0]      vset_q;
  logic [SP_W-1:0]      pset_q;
  logic [BRIGHT_W-1:0]  bright_q;
  logic [BCW-1:0]       blink_cnt_q;
  logic                 blink_ph_q;
  logic [3:0]           ident_q;
  logic                 led_zeroed_q;
  logic                 disp_on_q;
  logic [7:0]           lim_volts_q;
  logic [31:0]          prdata_q;
  logic                 pready_q;
  logic                 pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire apb_setup = psel & ~penable;
  wire apb_acc   = psel & penable & pready_q;
  wire hit_ctrl  = paddr == REG_CTRL;
  wire hit_stat  = paddr == REG_STATUS;
  wire hit_vset  = paddr == REG_VSET;
  wire hit_pset  = paddr == REG_PSET;
  wire hit_any   = hit_ctrl | hit_stat | hit_vset | hit_pset;
  wire ctrl_wr   = apb_acc & pwrite & hit_ctrl;
  wire host_id   = ctrl_wr & pwdata[CTRL_IDENT_BIT];
  wire host_zero = ctrl_wr & pwdata[CTRL_ZERO_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // mode decisions

  // resolution advances on release so a brightness gesture does not move it
  wire res_evt   = btn_rel[0] & ~res_used_q & ~(res_held & enc_step);
  wire bright_up = res_held & enc_cw & (bright_q != BRIGHT_MAX);
  wire bright_dn = res_held & enc_ccw & (bright_q != '0);
  wire lim_evt   = btn_rel[2];
  wire zero_req  = (btn_press[1] | host_zero) & ~zeroing_q;
  wire zero_end  = zeroing_q & zero_done;
  wire adj_step  = enc_step & ~res_held & ~lim_edit_q & (res_q != RES_PARKED);
  wire [2:0] unit_now = unit_f(lim_q);
  wire [SP_W-1:0] fine_stp   = SP_W'(unit_now);
  // widen both factors first so the product cannot wrap at the unit's width
  wire [SP_W-1:0] coarse_stp = SP_W'(unit_now) * SP_W'(COARSE_RATIO);
  wire [SP_W-1:0] step_sz    = (res_q == RES_COARSE) ? coarse_stp : fine_stp;

  fpdc_res_e res_next;
  fpdc_lim_e cand_next;
  fpdc_lim_e cand_prev;
  fpdc_lim_e lim_d;

  // resolution ring
  always_comb begin
    case (res_q)
      RES_COARSE: res_next = RES_FINE;
      RES_FINE:   res_next = RES_PARKED;
      RES_PARKED: res_next = RES_COARSE;
      default:    res_next = RES_COARSE;
    endcase
  end

  // candidate limit ring, both directions
  always_comb begin
    case (cand_q)
      LIM_75:  begin
        cand_next = LIM_100;
        cand_prev = LIM_150;
      end
      LIM_100: begin
        cand_next = LIM_150;
        cand_prev = LIM_75;
      end
      default: begin
        cand_next = LIM_75;
        cand_prev = LIM_100;
      end
    endcase
  end

  // legacy stage overrides any stored choice
  always_comb begin
    if (legacy) lim_d = LIM_75;
    else if (lim_edit_q && lim_evt) lim_d = cand_q;
    else lim_d = lim_q;
  end

  // the ceiling moves the same cycle as the limit
  wire [SP_W-1:0] ceil_d = ceil_f(lim_d);
  wire [SP_W-1:0] vset_adj = (adj_step && !closed_q) ?
                             sat_f(vset_q, step_sz, enc_cw, ceil_f(lim_q)) : vset_q;
  wire [SP_W-1:0] pset_adj = (adj_step && closed_q) ?
                             sat_f(pset_q, step_sz, enc_cw, ceil_f(lim_q)) : pset_q;

  ////////////////////////////////////////////////////////////////////////////
  // front-panel state

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      res_q      <= RES_COARSE;
      res_used_q <= 1'b0;
      bright_q   <= BRIGHT_RST;
    end else begin
      if (res_evt) res_q <= res_next;
      // a step in the press cycle still marks the gesture, so the set wins
      if (res_held && enc_step) res_used_q <= 1'b1;
      else if (btn_press[0]) res_used_q <= 1'b0;
      if (bright_up) bright_q <= bright_q + 1'b1;
      else if (bright_dn) bright_q <= bright_q - 1'b1;
    end
  end

  // limit selection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lim_q      <= LIM_150;
      cand_q     <= LIM_150;
      lim_edit_q <= 1'b0;
    end else begin
      lim_q <= lim_d;
      if (legacy) cand_q <= LIM_75;
      else if (!lim_edit_q && lim_evt) cand_q <= lim_q;
      else if (lim_edit_q && enc_cw && !res_held) cand_q <= cand_next;
      else if (lim_edit_q && enc_ccw && !res_held) cand_q <= cand_prev;
      if (lim_evt) lim_edit_q <= ~lim_edit_q;
    end
  end

  // setpoints, clamped to the ceiling of the limit in force next cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vset_q <= '0;
      pset_q <= '0;
    end else begin
      vset_q <= min_f(vset_adj, ceil_d);
      pset_q <= min_f(pset_adj, ceil_d);
    end
  end

  // loop, units and zeroing; zero completion outranks a loop press
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      closed_q     <= 1'b0;
      microns_q    <= 1'b0;
      zeroing_q    <= 1'b0;
      zeroed_q     <= 1'b0;
      zero_start_q <= 1'b0;
    end else begin
      zero_start_q <= zero_req;
      if (btn_press[4]) microns_q <= ~microns_q;
      if (zero_end) closed_q <= 1'b1;
      else if (btn_press[3] && !zeroing_q) closed_q <= ~closed_q;
      if (zero_req) begin
        zeroing_q <= 1'b1;
        zeroed_q  <= 1'b0;
      end else if (zero_end) begin
        zeroing_q <= 1'b0;
        zeroed_q  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // blinking and display

  wire blink_tick = blink_cnt_q == BLINK_TOP;

  // one shared phase keeps all blinking indicators in step
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      blink_cnt_q <= '0;
      blink_ph_q  <= 1'b0;
      ident_q     <= '0;
    end else begin
      blink_cnt_q <= blink_tick ? '0 : blink_cnt_q + 1'b1;
      if (blink_tick) blink_ph_q <= ~blink_ph_q;
      if (host_id) ident_q <= IDENT_HALF_BLINKS;
      else if (blink_tick && ident_q != '0) ident_q <= ident_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      led_zeroed_q <= 1'b0;
      disp_on_q    <= 1'b1;
      lim_volts_q  <= VOLTS_150;
    end else begin
      led_zeroed_q <= zeroing_q ? blink_ph_q : zeroed_q;
      disp_on_q    <= ~((lim_edit_q || ident_q != '0) && blink_ph_q);
      lim_volts_q  <= volts_f(lim_edit_q ? cand_q : lim_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, answer data latched in the setup cycle

  logic [31:0] status_w;
  always_comb begin
    status_w                 = '0;
    status_w[ST_CLOSED_BIT]  = closed_q;
    status_w[ST_ZEROED_BIT]  = zeroed_q;
    status_w[ST_ZEROING_BIT] = zeroing_q;
    status_w[ST_MICRONS_BIT] = microns_q;
    status_w[ST_LEDIT_BIT]   = lim_edit_q;
    status_w[ST_LEGACY_BIT]  = legacy;
    status_w[ST_IDENT_BIT]   = ident_q != '0;
    status_w[ST_RES_LSB+:2]  = res_q;
    status_w[ST_LIM_LSB+:2]  = lim_q;
    status_w[ST_BRIGHT_LSB+:BRIGHT_W] = bright_q;
  end

  wire [31:0] rd_mux = hit_stat ? status_w :
                       hit_vset ? {{(32-SP_W){1'b0}}, vset_q} :
                       hit_pset ? {{(32-SP_W){1'b0}}, pset_q} : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= apb_setup;
      pslverr_q <= apb_setup & ~hit_any;
      if (apb_setup) prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign volt_setpoint    = vset_q;
  assign pos_setpoint     = pset_q;
  assign drive_limit      = lim_q;
  assign res_mode         = res_q;
  assign zero_start       = zero_start_q;
  assign led_closed       = closed_q;
  assign led_zeroed       = led_zeroed_q;
  assign led_microns      = microns_q;
  assign disp_on          = disp_on_q;
  assign disp_limit_mode  = lim_edit_q;
  assign disp_limit_volts = lim_volts_q;
  assign disp_brightness  = bright_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_RES_RING: assert property (res_evt && res_q == RES_FINE |=> res_q == RES_PARKED)
    else $error("resolution did not advance fine to parked");
  AST_COARSE_TEN: assert property (adj_step && !closed_q && enc_cw && res_q == RES_COARSE
    && !legacy && !lim_evt && {1'b0, vset_q} + {1'b0, coarse_stp} <= {1'b0, ceil_f(lim_q)}
    |=> vset_q == $past(vset_q) + SP_W'(10 * int'(unit_f(lim_q))))
    else $error("coarse step is not ten fine steps");
  AST_PARKED: assert property (enc_step && res_q == RES_PARKED && !lim_evt && !legacy
    |=> $stable(vset_q) && $stable(pset_q))
    else $error("parked encoder moved a setpoint");
  AST_ZERO_BLINK: assert property (zeroing_q && $rose(blink_ph_q) |=> led_zeroed_q)
    else $error("zeroed led not blinking during zeroing");
  AST_ZERO_END: assert property (zero_end && !zero_req ##1 1 |=> led_zeroed_q && closed_q
    && !zeroing_q)
    else $error("zeroing end did not close the loop with led on");
  AST_LIM_STORE: assert property (lim_edit_q && lim_evt && !legacy
    |=> lim_q == $past(cand_q) && !lim_edit_q)
    else $error("limit not stored on second press");
  AST_LEGACY: assert property (legacy |=> lim_q == LIM_75 && cand_q == LIM_75)
    else $error("legacy stage did not force 75 V");
  AST_CEIL: assert property (vset_q <= ceil_f(lim_q) && pset_q <= ceil_f(lim_q))
    else $error("setpoint above active ceiling");
  AST_FLOOR_UP: assert property (adj_step && !closed_q && enc_cw && vset_q == '0 && !legacy
    |=> vset_q != '0)
    else $error("first clockwise step from zero did not raise setpoint");
  AST_BRIGHT: assert property (bright_up |=> bright_q == $past(bright_q) + 1'b1
    && $stable(vset_q) && $stable(pset_q))
    else $error("brightness gesture misbehaved");
  AST_IDENT: assert property (host_id |=> ident_q == IDENT_HALF_BLINKS)
    else $error("identify request not taken");
endmodule // fpdc_front_panel

// ---- sim/fpdc_operator.sv ----
// operator model: front-panel buttons and quadrature encoder
`timescale 1ns/10ps
module fpdc_operator (
  input  wire logic clk,
  output logic      btn_res,
  output logic      btn_zero,
  output logic      btn_lim,
  output logic      btn_loop,
  output logic      btn_unit,
  output logic      enc_a,
  output logic      enc_b
);
  logic [4:0] btn_q;
  // index order: res, zero, lim, loop, unit
  assign {btn_unit, btn_loop, btn_lim, btn_zero, btn_res} = btn_q;
  // all released at time zero
  initial begin
    btn_q = 5'h00;
    enc_a = 1'b0;
    enc_b = 1'b0;
  end
  // held well past the filter so each level counts
  task automatic hold(input int idx, input logic lvl);
    // contact bounce shorter than the filter must be rejected
    repeat (2) begin
      btn_q[idx] <= 1'($urandom);
      @(posedge clk);
    end
    btn_q[idx] <= lvl;
    repeat (14) @(posedge clk);
  endtask
  task automatic tap(input int idx);
    hold(idx, 1'b1);
    hold(idx, 1'b0);
  endtask
  // one detent: direction on b settles before a rises
  task automatic turn(input logic cw);
    // b may wander while a is low; only its level at the rise of a counts
    enc_b <= 1'($urandom);
    repeat (3) @(posedge clk);
    enc_b <= ~cw;
    repeat (6) @(posedge clk);
    enc_a <= 1'b1;
    repeat (6) @(posedge clk);
    enc_a <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule // fpdc_operator

// ---- sim/tb_top.sv ----
// self-checking bench for the front-panel drive control block
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
  import fpdc_pkg::*;
  localparam int DET = 2;
  logic clk = 1'b0, rst_n, legacy, zdone;
  logic psel, penable, pwrite, pready, pslverr, zero_start;
  logic [7:0] paddr, disp_limit_volts;
  logic [31:0] pwdata, prdata;
  logic [SP_W-1:0] volt_setpoint, pos_setpoint, vsp;
  logic [1:0] drive_limit, res_mode;
  logic led_closed, led_zeroed, led_microns, disp_on, disp_limit_mode;
  logic [3:0] disp_brightness;
  wire b_res, b_zero, b_lim, b_loop, b_unit, ea, eb;
  int error_cnt = 0, check_count = 0, zs_cnt = 0;
  // 50 MHz clock
  always #10 clk = ~clk;
  // count zeroing start pulses
  always @(posedge clk) if (zero_start === 1'b1) zs_cnt++;
  fpdc_operator i_fpdc_operator (.clk(clk), .btn_res(b_res), .btn_zero(b_zero),
    .btn_lim(b_lim), .btn_loop(b_loop), .btn_unit(b_unit), .enc_a(ea), .enc_b(eb));
  fpdc_front_panel #(.DEBOUNCE_CNT(4), .ENC_FILT_CNT(2), .BLINK_CNT(8), .ENC_DET(DET))
  i_fpdc_front_panel (.clk(clk), .rst_n(rst_n), .btn_res(b_res), .btn_zero(b_zero),
    .btn_lim(b_lim), .btn_loop(b_loop), .btn_unit(b_unit), .enc_a(ea), .enc_b(eb),
    .legacy_stage(legacy), .zero_done(zdone), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .volt_setpoint(volt_setpoint), .pos_setpoint(pos_setpoint),
    .drive_limit(drive_limit), .res_mode(res_mode), .zero_start(zero_start),
    .led_closed(led_closed), .led_zeroed(led_zeroed), .led_microns(led_microns),
    .disp_on(disp_on), .disp_limit_mode(disp_limit_mode),
    .disp_limit_volts(disp_limit_volts), .disp_brightness(disp_brightness));
  // clamp ceiling scales with the unit of the active limit
  function automatic int ceil_of(input logic [1:0] lim);
    return DET * FULL_TURNS * COARSE_RATIO * ((lim == 2'h0) ? UNIT_75 :
      (lim == 2'h1) ? UNIT_100 : UNIT_150);
  endfunction
  function automatic logic [SP_W-1:0] nxt(input logic [SP_W-1:0] sp, input logic up,
                                          input logic crs, input logic [1:0] lim);
    int s;
    s = ceil_of(lim) / (DET * FULL_TURNS * COARSE_RATIO);
    s = crs ? s * COARSE_RATIO : s;
    s = up ? sp + s : sp - s;
    s = (s < 0) ? 0 : (s > ceil_of(lim)) ? ceil_of(lim) : s;
    return s[SP_W-1:0];
  endfunction
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic conclude;
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard, far beyond the expected few thousand cycles
  initial begin
    #400000;
    error_cnt++;
    conclude();
  end
  // main sequence
  initial begin
    logic [31:0] q;
    logic e;
    int k;
    void'($urandom(32'hc6f9369b));
    rst_n <= 1'b0;
    legacy <= 1'b0;
    zdone <= 1'($urandom);
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0000_0000;
    vsp = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK(res_mode, 2'h0)
    for (k = 0; k < 3; k++) begin
      i_fpdc_operator.turn(1'b1);
      if (k < 2) vsp = nxt(vsp, 1'b1, k == 0, drive_limit);
      `CHK(volt_setpoint, vsp)
      i_fpdc_operator.tap(0);
      `CHK(res_mode, 2'((k + 1) % 3))
    end
    // random overdrive past the ceiling, then back off once
    k = 26 + $urandom % 6;
    repeat (k) begin
      i_fpdc_operator.turn(1'b1);
      vsp = nxt(vsp, 1'b1, 1'b1, 2'h2);
    end
    `CHK(volt_setpoint, vsp)
    i_fpdc_operator.turn(1'b0);
    vsp = nxt(vsp, 1'b0, 1'b1, 2'h2);
    `CHK(volt_setpoint, vsp)
    i_fpdc_operator.tap(2);
    `CHK(disp_limit_mode, 1'b1)
    i_fpdc_operator.turn(1'b0);
    `CHK(disp_limit_volts, VOLTS_100)
    `CHK(volt_setpoint, vsp)
    i_fpdc_operator.tap(2);
    `CHK(drive_limit, 2'h1)
    vsp = (vsp > ceil_of(2'h1)) ? SP_W'(ceil_of(2'h1)) : vsp;
    `CHK(volt_setpoint, vsp)
    k = 26 + $urandom % 6;
    repeat (k) i_fpdc_operator.turn(1'b0);
    i_fpdc_operator.turn(1'b1);
    vsp = nxt(SP_W'(0), 1'b1, 1'b1, 2'h1);
    `CHK(volt_setpoint, vsp)
    i_fpdc_operator.tap(3);
    `CHK(led_closed, 1'b1)
    i_fpdc_operator.turn(1'b1);
    `CHK(pos_setpoint, nxt(SP_W'(0), 1'b1, 1'b1, 2'h1))
    i_fpdc_operator.tap(4);
    `CHK(led_microns, 1'b1)
    // brightness gesture: turn with resolution held
    i_fpdc_operator.hold(0, 1'b1);
    i_fpdc_operator.turn(1'b1);
    i_fpdc_operator.hold(0, 1'b0);
    `CHK(disp_brightness, BRIGHT_RST + 4'h1)
    `CHK({res_mode, pos_setpoint}, {2'h0, nxt(SP_W'(0), 1'b1, 1'b1, 2'h1)})
    i_fpdc_operator.tap(3);
    `CHK(led_closed, 1'b0)
    zdone <= 1'b0;
    apb(1'b0, REG_VSET, 32'h0000_0000, q, e);
    `CHK(q, 32'(vsp))
    apb(1'b1, REG_CTRL, 32'h2 | ($urandom & 32'hFFFF_FFFC), q, e);
    apb(1'b0, REG_STATUS, 32'h0, q, e);
    `CHK(q[ST_ZEROING_BIT], 1'b1)
    `CHK(zs_cnt, 1)
    k = 0;
    repeat (40) @(posedge clk) k += led_zeroed;
    `CHK(k > 0 && k < 40, 1'b1)
    zdone <= 1'b1;
    repeat (3) @(posedge clk);
    zdone <= 1'b0;
    `CHK({led_closed, led_zeroed}, 2'h3)
    apb(1'b1, REG_CTRL, 32'h1 | ($urandom & 32'hFFFF_FFFC), q, e);
    k = 0;
    repeat (60) @(posedge clk) k += !disp_on;
    `CHK(k > 0, 1'b1)
    apb(1'($urandom), 8'h10 + 8'($urandom % 240), 32'($urandom), q, e);
    `CHK({e, q}, 33'h100000000)
    legacy <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK(drive_limit, 2'h0)
    conclude();
  end
endmodule // tb_top
